// ---- bench/psfm_analog_model.sv ----
/*
 * far-side model: switching clock source and soft-start circuit.
 * assumes the supervisor pulses soft_start_restart and holds switching_stop while off.
 */
module psfm_analog_model #(
	parameter int SW_HALF = 5,
	parameter int SS_CYC  = 12
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// supervisor side
	input  wire logic soft_start_restart,
	input  wire logic switching_stop,
	// analog side
	output      logic sw_clk,
	output      logic soft_start_done
);
	timeunit 1ns;
	timeprecision 1ns;
	int sw_n;
	int ss_n;
	////////////////////////////////////////////////////////////////////////////////
	// switching clock stands still while switching is stopped, as the real oscillator gate does
	always_ff @(posedge clk) begin
		if (reset || switching_stop) begin
			sw_n <= 0;
			sw_clk <= 1'b0;
		end else if (sw_n == SW_HALF - 1) begin
			sw_n <= 0;
			sw_clk <= !sw_clk;
		end else begin
			sw_n <= sw_n + 1;
		end
	end
	// soft-start ramp finishes a fixed time after each restart; a stop discharges it
	always_ff @(posedge clk) begin
		if (reset) begin
			ss_n <= 0;
			soft_start_done <= 1'b0;
		end else if (soft_start_restart) begin
			ss_n <= SS_CYC;
			soft_start_done <= 1'b0;
		end else begin
			ss_n <= (ss_n > 0) ? ss_n - 1 : 0;
			if (switching_stop)
				soft_start_done <= 1'b0;
			else if (ss_n == 1)
				soft_start_done <= 1'b1;
		end
	end
endmodule // psfm_analog_model

// ---- bench/psfm_top_test.sv ----
/*
 * self-checking bench for the phase shedding and fault supervisor.
 * assumes short lockout, power-good and hiccup counts set below; flags driven raw.
 */
module psfm_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LK = 40;
	localparam int PG = 20;
	localparam int HC = 60;
	logic clk = 1'b0;
	logic reset = 1'b1;
	psfm_pkg::psfm_cmp_t fl = 16'h0040;
	psfm_pkg::psfm_cmp_t cmp_w;
	logic [1:0] mode = psfm_pkg::LLM_LOW;
	logic frs = 1'b1;
	logic ext = 1'b0;
	logic en = 1'b0;
	logic ss_done;
	logic sw_w;
	psfm_pkg::psfm_drv_t drv;
	logic switching_stop, soft_start_restart, power_good_output, diode_emulation_active;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata, q;
	logic avs_waitrequest;
	int n_mismatch = 0;
	int total_checks = 0;
	int seed, n, m, fexp;
	// reference model: sticky fault log and queued light-load requests
	int flog_m = 0;
	logic [3:0] zq[$];
	logic prev;
	assign cmp_w = {sw_w, fl[$bits(fl)-2:0]};
	initial forever #50 clk = !clk;
	psfm_top #(.LOCKOUT_CYCLES(LK), .PG_DELAY_CYCLES(PG), .HICCUP_CYCLES(HC)) uut (
		.clk(clk), .reset(reset), .cmp_raw(cmp_w), .light_load_mode_select(mode),
		.fault_response_select(frs), .ext_sync_active(ext), .enable_pin(en),
		.soft_start_done(ss_done), .drv(drv), .switching_stop(switching_stop),
		.soft_start_restart(soft_start_restart), .power_good_output(power_good_output),
		.diode_emulation_active(diode_emulation_active), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	psfm_analog_model model (.clk(clk), .reset(reset), .soft_start_restart(soft_start_restart),
		.switching_stop(switching_stop), .sw_clk(sw_w), .soft_start_done(ss_done));
	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// one request held until waitrequest samples low; an idle edge keeps drivers single per step
	// no local limit: only the watchdog ends a stuck wait
	task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk);
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(logic [3:0] a, logic [31:0] mask, logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		check("reg", q & mask, exp);
	endtask
	function automatic logic c(int s);
		case (s)
			0: return soft_start_restart === 1'b1;
			1: return switching_stop === 1'b1;
			2: return drv.phase2_enable === 1'b0;
			3: return drv.phase2_enable === 1'b1;
			4: return drv.phase2_duty_scale !== 4'h8;
			default: return power_good_output === 1'b1;
		endcase
	endfunction
	task automatic wt(int s, int lim);
		n = 0;
		while (!c(s) && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (!c(s)) begin
			n_mismatch++;
			$display("[FAIL] wait %0d exp 1 seen 0", s);
		end
	endtask
	task automatic sf(int k, logic v);
		case (k)
			0: fl.input_ov <= v;
			1: fl.avg_oc <= v;
			2: fl.peak_oc <= v;
			3: fl.output_ov <= v;
			4: fl.lf_short <= v;
			default: fl.freq_low <= v;
		endcase
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		complete_run();
	end
	initial begin
		seed = 26144;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(4'h0, 32'h0000_0001, 32'h0000_0001);
		rd(4'hc, 32'hffff_ffff, 32'h0000_0000);
		en <= 1'b1;
		wt(0, 10);
		repeat (3) @(posedge clk);
		check("emu_ss", diode_emulation_active, 1'b1);
		wt(5, PG + 30);
		check("pg_dly", n >= PG, 1'b1);
		for (m = 0; m < 3; m++) begin
			mode <= m[1:0];
			repeat (4) @(posedge clk);
			check("emu_mode", diode_emulation_active, m != 0);
		end
		for (m = 0; m < 8; m++) begin
			fexp = $random(seed);
			zq.push_back(fexp[3:0]);
			fl.zero_cross <= fexp[1:0];
			fl.skip_req <= fexp[3:2];
			repeat (5) @(posedge clk);
			check("sync_off", drv.sync_switch_off, zq[0][1:0]);
			check("skip", drv.skip_pulse, zq[0][3:2]);
			zq.delete(0);
		end
		fl.zero_cross <= 2'h0;
		fl.skip_req <= 2'h0;
		mode <= psfm_pkg::LLM_FLOAT;
		fl.avg_below_drop <= 1'b1;
		m = 0;
		// sync and step latency: the first step shows at the next switching edge, within the 20-clock wait (two switching cycles)
		wt(4, 20);
		prev = sw_w;
		while (drv.phase2_enable === 1'b1 && m < 20) begin
			@(posedge clk);
			m += (sw_w && !prev);
			prev = sw_w;
		end
		// the step already seen counts as the first switching cycle of the ramp
		check("ramp_n", m + 1 >= 8 && m + 1 <= 10, 1'b1);
		check("duty0", drv.phase2_duty_scale, 4'h0);
		fl.avg_above_add <= 1'b1;
		wt(3, 6);
		fl.avg_above_add <= 1'b0;
		rd(4'h4, 32'h0000_0020, 32'h0000_0020);
		wt(4, LK + 20);
		check("lock_n", n >= LK - 8, 1'b1);
		for (m = 0; m < 2; m++) begin
			wt(2, LK + 120);
			fl.peak_current_limit <= 2'h1 << m;
			wt(3, 6);
			fl.peak_current_limit <= 2'h0;
		end
		ext <= 1'b1;
		wt(3, LK + 40);
		repeat (LK + 20) @(posedge clk);
		check("sync_keep", drv.phase2_enable, 1'b1);
		ext <= 1'b0;
		fl.avg_below_drop <= 1'b0;
		fl.input_ov <= 1'b1;
		repeat (30) @(posedge clk);
		fl.input_ov <= 1'b0;
		check("ov_short", switching_stop, 1'b0);
		for (m = 0; m < 6; m++) begin
			sf(m, 1'b1);
			fl.output_ov_clear <= (m != 3);
			wt(1, 80);
			check("pg_low", power_good_output, 1'b0);
			fexp = 1 << m;
			flog_m = flog_m | fexp;
			rd(4'h8, 32'h0000_003f, flog_m);
			sf(m, 1'b0);
			bus(1'b1, 4'h8, fexp);
			flog_m = flog_m & ~fexp;
			fl.output_ov_clear <= 1'b1;
			rd(4'h8, 32'h0000_003f, flog_m);
			wt(0, HC + 10);
			check("hic_n", n >= HC - 12, 1'b1);
			wt(5, PG + 40);
		end
		frs <= 1'b0;
		fl.lf_short <= 1'b1;
		wt(1, 20);
		fl.lf_short <= 1'b0;
		repeat (HC * 2) @(posedge clk);
		check("latched", switching_stop, 1'b1);
		rd(4'h4, 32'h0000_0007, 32'h0000_0004);
		bus(1'b1, 4'h8, 32'h0000_003f);
		en <= 1'b0;
		fl.freq_low <= 1'b1;
		repeat (10) @(posedge clk);
		rd(4'h8, 32'h0000_003f, 32'h0000_0000);
		fl.freq_low <= 1'b0;
		repeat (4) @(posedge clk);
		en <= 1'b1;
		wt(0, 10);
		complete_run();
	end
endmodule // psfm_top_test

// ---- include/psfm_pkg.sv ----
/*
 * shared constants and carriers for the phase shedding and fault manager.
 * assumes a single 10 MHz clock; the time figures below derive cycle counts from it.
 */
package psfm_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_FREQ_HZ    = 10_000_000;
	localparam int CLK_PER_US     = CLK_FREQ_HZ / 1_000_000;
	localparam int T_VINOV_US     = 5;
	localparam int T_LOCKOUT_US   = 1500;
	localparam int T_PG_DELAY_US  = 500;
	localparam int T_HICCUP_MS    = 500;
	localparam int VINOV_CYC      = T_VINOV_US * CLK_PER_US;
	localparam int LOCKOUT_CYC    = T_LOCKOUT_US * CLK_PER_US;
	localparam int PG_DELAY_CYC   = T_PG_DELAY_US * CLK_PER_US;
	localparam int HICCUP_CYC     = T_HICCUP_MS * 1000 * CLK_PER_US;
	localparam int CNT_W          = 24;
	localparam logic [3:0] RAMP_STEPS = 4'h8;

	////////////////////////////////////////////////////////////////////////////////
	// light-load mode select encoding (3'rd code treated as high)
	localparam logic [1:0] LLM_LOW   = 2'h0;
	localparam logic [1:0] LLM_FLOAT = 2'h1;
	localparam logic [1:0] LLM_HIGH  = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// register map, byte addresses
	localparam logic [3:0]  REG_CTRL_OFS   = 4'h0;
	localparam logic [3:0]  REG_STATUS_OFS = 4'h4;
	localparam logic [3:0]  REG_FAULT_OFS  = 4'h8;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
	localparam logic [31:0] FAULT_RESET    = 32'h0000_0000;
	localparam int CTRL_SHED_ALLOW = 0;
	localparam int STAT_STATE_LSB  = 0;
	localparam int STAT_P2_ON      = 4;
	localparam int STAT_LOCKOUT    = 5;
	localparam int STAT_DIODE_EMU  = 6;
	localparam int STAT_PG         = 7;
	localparam int STAT_SHED_EN    = 8;

	// fault bit positions
	localparam int FLT_INPUT_OV  = 0;
	localparam int FLT_AVG_OC    = 1;
	localparam int FLT_PEAK_OC   = 2;
	localparam int FLT_OUTPUT_OV = 3;
	localparam int FLT_LF_SHORT  = 4;
	localparam int FLT_LOCK_LOSS = 5;
	localparam int NUM_FAULTS    = 6;

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic       sw_clk;
		logic       avg_below_drop;
		logic       avg_above_add;
		logic [1:0] peak_current_limit;
		logic       avg_oc;
		logic       peak_oc;
		logic       input_ov;
		logic       output_ov;
		logic       output_ov_clear;
		logic       lf_short;
		logic       freq_low;
		logic [1:0] zero_cross;
		logic [1:0] skip_req;
	} psfm_cmp_t;

	typedef struct packed {
		logic       phase2_enable;
		logic [3:0] phase2_duty_scale;
		logic [1:0] sync_switch_off;
		logic [1:0] skip_pulse;
	} psfm_drv_t;

	typedef enum logic [2:0] {ST_OFF, ST_SOFTSTART, ST_RUN, ST_HICCUP, ST_LATCHED} psfm_state_t;
	typedef enum logic [1:0] {P2_ON, P2_RAMP, P2_OFF} psfm_p2_t;

endpackage

// ---- rtl/psfm_top.sv ----
/*
 * phase shedding, light-load mode and fault response supervisor for a two-phase boost.
 * assumes comparator flags arrive raw from analog and are synchronised here; soft-start
 * circuitry reports completion; register access by an avalon-mm master.
 */
module psfm_top #(
	parameter int LOCKOUT_CYCLES  = psfm_pkg::LOCKOUT_CYC,
	parameter int PG_DELAY_CYCLES = psfm_pkg::PG_DELAY_CYC,
	parameter int HICCUP_CYCLES   = psfm_pkg::HICCUP_CYC
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                reset,
	// analog comparator flags
	input  wire psfm_pkg::psfm_cmp_t cmp_raw,
	// configuration pins and soft-start completion
	input  wire logic [1:0]          light_load_mode_select,
	input  wire logic                fault_response_select,
	input  wire logic                ext_sync_active,
	input  wire logic                enable_pin,
	input  wire logic                soft_start_done,
	// drive outputs
	output      psfm_pkg::psfm_drv_t drv,
	output      logic                switching_stop,
	output      logic                soft_start_restart,
	output      logic                power_good_output,
	output      logic                diode_emulation_active,
	// avalon-mm slave
	input  wire logic [3:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	output      logic [31:0]         avs_readdata,
	output      logic                avs_waitrequest
);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [psfm_pkg::CNT_W-1:0] cnt_dec(input logic [psfm_pkg::CNT_W-1:0] c);
		cnt_dec = (c == '0) ? '0 : c - 1'b1;
	endfunction

	localparam logic [psfm_pkg::CNT_W-1:0] LOCK_LOAD = psfm_pkg::CNT_W'(LOCKOUT_CYCLES);
	localparam logic [psfm_pkg::CNT_W-1:0] PG_LOAD   = psfm_pkg::CNT_W'(PG_DELAY_CYCLES);
	localparam logic [psfm_pkg::CNT_W-1:0] HIC_LOAD  = psfm_pkg::CNT_W'(HICCUP_CYCLES);
	localparam logic [5:0]                 VINOV_MAX = 6'(psfm_pkg::VINOV_CYC);

	////////////////////////////////////////////////////////////////////////////////
	// synchronisers; the first stage is read only by the second
	psfm_pkg::psfm_cmp_t sync1_q, sync2_q;
	logic                sw_prev_q;
	psfm_pkg::psfm_cmp_t cmp;
	logic                sw_tick;

	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_q   <= '0;
			sync2_q   <= '0;
			sw_prev_q <= 1'b0;
		end else begin
			sync1_q   <= cmp_raw;
			sync2_q   <= sync1_q;
			sw_prev_q <= sync2_q.sw_clk;
		end
	end

	always_comb begin
		cmp     = sync2_q;
		sw_tick = sync2_q.sw_clk & ~sw_prev_q;
	end

	////////////////////////////////////////////////////////////////////////////////
	// fault detection and response state
	psfm_pkg::psfm_state_t         st_q, st_d;
	logic [psfm_pkg::CNT_W-1:0]    hic_q, hic_d;
	logic [5:0]                    vinov_q, vinov_d;
	logic                          ovhold_q, ovhold_d;
	logic                          restart_q, restart_d;
	logic [psfm_pkg::NUM_FAULTS-1:0] fault_now;
	logic                          armed, any_fault;

	always_comb begin
		armed   = (st_q == psfm_pkg::ST_SOFTSTART) || (st_q == psfm_pkg::ST_RUN);
		vinov_d = (armed && cmp.input_ov) ? ((vinov_q == VINOV_MAX) ? vinov_q : vinov_q + 6'h01) : 6'h00;
		// hold output overvoltage until feedback falls below trip minus hysteresis
		ovhold_d = ovhold_q;
		if (ovhold_q && cmp.output_ov_clear)
			ovhold_d = 1'b0;
		if (armed && cmp.output_ov)
			ovhold_d = 1'b1;
		fault_now = '0;
		fault_now[psfm_pkg::FLT_INPUT_OV]  = vinov_q == VINOV_MAX;
		fault_now[psfm_pkg::FLT_AVG_OC]    = armed & cmp.avg_oc;
		fault_now[psfm_pkg::FLT_PEAK_OC]   = armed & cmp.peak_oc;
		fault_now[psfm_pkg::FLT_OUTPUT_OV] = armed & ovhold_q;
		fault_now[psfm_pkg::FLT_LF_SHORT]  = armed & cmp.lf_short;
		fault_now[psfm_pkg::FLT_LOCK_LOSS] = armed & cmp.freq_low;
		any_fault = |fault_now;

		st_d      = st_q;
		hic_d     = cnt_dec(hic_q);
		restart_d = 1'b0;
		case (st_q)
			psfm_pkg::ST_OFF: begin
				if (enable_pin) begin
					st_d      = psfm_pkg::ST_SOFTSTART;
					restart_d = 1'b1;
				end
			end
			psfm_pkg::ST_SOFTSTART, psfm_pkg::ST_RUN: begin
				if (!enable_pin) begin
					st_d = psfm_pkg::ST_OFF;
				end else if (any_fault) begin
					// pin high means hiccup, low means latch-off
					st_d  = fault_response_select ? psfm_pkg::ST_HICCUP : psfm_pkg::ST_LATCHED;
					hic_d = HIC_LOAD;
				end else if (st_q == psfm_pkg::ST_SOFTSTART && soft_start_done) begin
					st_d = psfm_pkg::ST_RUN;
				end
			end
			psfm_pkg::ST_HICCUP: begin
				if (!enable_pin) begin
					st_d = psfm_pkg::ST_OFF;
				end else if (hic_q == '0) begin
					// a still-high output overvoltage keeps the wait going
					if (ovhold_q) begin
						hic_d = HIC_LOAD;
					end else begin
						st_d      = psfm_pkg::ST_SOFTSTART;
						restart_d = 1'b1;
					end
				end
			end
			psfm_pkg::ST_LATCHED: begin
				// only an enable low (or reset) frees the latch
				if (!enable_pin)
					st_d = psfm_pkg::ST_OFF;
			end
			default: st_d = psfm_pkg::ST_OFF;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_q      <= psfm_pkg::ST_OFF;
			hic_q     <= '0;
			vinov_q   <= 6'h00;
			ovhold_q  <= 1'b0;
			restart_q <= 1'b0;
		end else begin
			st_q      <= st_d;
			hic_q     <= hic_d;
			vinov_q   <= vinov_d;
			ovhold_q  <= ovhold_d;
			restart_q <= restart_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// power good: released only after a quiet run of the delay
	logic [psfm_pkg::CNT_W-1:0] pgc_q, pgc_d;
	logic                       pg_q, pg_d;

	always_comb begin
		pgc_d = PG_LOAD;
		pg_d  = 1'b0;
		if (st_q == psfm_pkg::ST_RUN && !any_fault) begin
			pgc_d = cnt_dec(pgc_q);
			pg_d  = (pgc_q == '0);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pgc_q <= '0;
			pg_q  <= 1'b0;
		end else begin
			pgc_q <= pgc_d;
			pg_q  <= pg_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers
	logic [31:0] ctrl_q, ctrl_d;
	logic [31:0] flog_q, flog_d;
	logic [31:0] rdata_q, rdata_d;
	logic        ack_q, ack_d;
	logic [31:0] status;
	logic        wr_ctrl, wr_flog;

	// phase-2 state, declared early for status
	psfm_pkg::psfm_p2_t         p2_q, p2_d;
	logic [3:0]                 duty_q, duty_d;
	logic [psfm_pkg::CNT_W-1:0] lock_q, lock_d;
	logic                       shed_en, emu_on;

	always_comb begin
		status = '0;
		status[psfm_pkg::STAT_STATE_LSB +: 3] = st_q;
		status[psfm_pkg::STAT_P2_ON]   = p2_q == psfm_pkg::P2_ON;
		status[psfm_pkg::STAT_LOCKOUT] = lock_q != '0;
		status[psfm_pkg::STAT_DIODE_EMU] = emu_on;
		status[psfm_pkg::STAT_PG]      = pg_q;
		status[psfm_pkg::STAT_SHED_EN] = shed_en;
	end

	always_comb begin
		// one wait state: answer at the second edge of the request
		ack_d   = (avs_read | avs_write) & ~ack_q;
		wr_ctrl = ack_q & avs_write & (avs_address == psfm_pkg::REG_CTRL_OFS);
		wr_flog = ack_q & avs_write & (avs_address == psfm_pkg::REG_FAULT_OFS);
		ctrl_d  = ctrl_q;
		if (wr_ctrl)
			ctrl_d = {31'h0000_0000, avs_writedata[psfm_pkg::CTRL_SHED_ALLOW]};
		// write one to clear; a fault in the same cycle wins
		flog_d = flog_q;
		if (wr_flog)
			flog_d = flog_q & ~avs_writedata;
		flog_d[psfm_pkg::NUM_FAULTS-1:0] = flog_d[psfm_pkg::NUM_FAULTS-1:0] | fault_now;
		rdata_d = rdata_q;
		if (ack_d && avs_read) begin
			case (avs_address)
				psfm_pkg::REG_CTRL_OFS:   rdata_d = ctrl_q;
				psfm_pkg::REG_STATUS_OFS: rdata_d = status;
				psfm_pkg::REG_FAULT_OFS:  rdata_d = flog_q;
				default:                  rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_q  <= psfm_pkg::CTRL_RESET;
			flog_q  <= psfm_pkg::FAULT_RESET;
			rdata_q <= 32'h0000_0000;
			ack_q   <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			flog_q  <= flog_d;
			rdata_q <= rdata_d;
			ack_q   <= ack_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// phase shedding
	logic add_req;

	always_comb begin
		// floating pin enables shedding; never on an external sync clock
		shed_en = (light_load_mode_select == psfm_pkg::LLM_FLOAT)
			& ~ext_sync_active
			& ctrl_q[psfm_pkg::CTRL_SHED_ALLOW]
			& (st_q == psfm_pkg::ST_RUN);
		add_req = cmp.avg_above_add | (|cmp.peak_current_limit);
		p2_d    = p2_q;
		duty_d  = duty_q;
		lock_d  = cnt_dec(lock_q);
		case (p2_q)
			psfm_pkg::P2_ON: begin
				if (shed_en && lock_q == '0 && cmp.avg_below_drop && !add_req)
					p2_d = psfm_pkg::P2_RAMP;
			end
			psfm_pkg::P2_RAMP, psfm_pkg::P2_OFF: begin
				if (add_req || !shed_en) begin
					p2_d   = psfm_pkg::P2_ON;
					duty_d = psfm_pkg::RAMP_STEPS;
					if (add_req)
						lock_d = LOCK_LOAD;
				end else if (p2_q == psfm_pkg::P2_RAMP && sw_tick) begin
					// one step per switching cycle keeps the loop calm
					duty_d = duty_q - 4'h1;
					if (duty_q == 4'h1)
						p2_d = psfm_pkg::P2_OFF;
				end
			end
			default: begin
				p2_d   = psfm_pkg::P2_ON;
				duty_d = psfm_pkg::RAMP_STEPS;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			p2_q   <= psfm_pkg::P2_ON;
			duty_q <= psfm_pkg::RAMP_STEPS;
			lock_q <= '0;
		end else begin
			p2_q   <= p2_d;
			duty_q <= duty_d;
			lock_q <= lock_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// light-load conduction and outputs
	psfm_pkg::psfm_drv_t drv_q, drv_d;
	logic                stop_q, stop_d;
	logic                emu_q;

	always_comb begin
		emu_on = (light_load_mode_select != psfm_pkg::LLM_LOW)
			| (st_q == psfm_pkg::ST_SOFTSTART);
		drv_d.phase2_enable     = p2_q != psfm_pkg::P2_OFF;
		drv_d.phase2_duty_scale = duty_q;
		drv_d.sync_switch_off   = {2{emu_on}} & cmp.zero_cross;
		drv_d.skip_pulse        = {2{emu_on}} & cmp.skip_req;
		stop_d = !(st_d == psfm_pkg::ST_SOFTSTART || st_d == psfm_pkg::ST_RUN);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			drv_q  <= '0;
			stop_q <= 1'b1;
			emu_q  <= 1'b0;
		end else begin
			drv_q  <= drv_d;
			stop_q <= stop_d;
			emu_q  <= emu_on;
		end
	end

	assign drv                    = drv_q;
	assign switching_stop         = stop_q;
	assign soft_start_restart     = restart_q;
	assign power_good_output      = pg_q;
	assign diode_emulation_active = emu_q;
	assign avs_readdata           = rdata_q;
	assign avs_waitrequest        = (avs_read | avs_write) & ~ack_q;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_drop_starts_ramp: assert property (
		p2_q == psfm_pkg::P2_ON && shed_en && lock_q == '0 && cmp.avg_below_drop && !add_req
		|=> p2_q == psfm_pkg::P2_RAMP) else $error("phase 2 did not start ramping");
	a_ramp_one_step: assert property (
		p2_q == psfm_pkg::P2_RAMP && sw_tick && !add_req && shed_en
		|=> duty_q == $past(duty_q) - 4'h1) else $error("ramp step wrong");
	a_ext_sync_blocks: assert property (
		ext_sync_active && p2_q == psfm_pkg::P2_ON |=> p2_q == psfm_pkg::P2_ON)
		else $error("shed under external sync");
	a_add_immediate: assert property (
		p2_q != psfm_pkg::P2_ON && add_req |=> p2_q == psfm_pkg::P2_ON ##1 drv.phase2_enable)
		else $error("phase 2 not added");
	a_lockout_hold: assert property (
		p2_q != psfm_pkg::P2_ON && add_req |=> (p2_q == psfm_pkg::P2_ON) [*8])
		else $error("shed during lockout");
	a_de_softstart: assert property (
		st_q == psfm_pkg::ST_SOFTSTART |=> diode_emulation_active)
		else $error("no diode emulation in soft-start");
	a_fault_response: assert property (
		armed && any_fault && enable_pin
		|=> st_q == ($past(fault_response_select) ? psfm_pkg::ST_HICCUP : psfm_pkg::ST_LATCHED) ##1 switching_stop)
		else $error("wrong fault response");
	a_latch_holds: assert property (
		st_q == psfm_pkg::ST_LATCHED && enable_pin |=> st_q == psfm_pkg::ST_LATCHED)
		else $error("latch-off released");
	a_vinov_filter: assert property (
		armed && !cmp.input_ov ##1 (armed && cmp.input_ov) [*8] |-> !fault_now[psfm_pkg::FLT_INPUT_OV])
		else $error("input overvoltage too early");
	a_pg_low_fault: assert property (
		any_fault |=> !power_good_output) else $error("power good high on fault");

	c_shed_done: cover property (p2_q == psfm_pkg::P2_RAMP ##[1:300] p2_q == psfm_pkg::P2_OFF);
	c_hiccup_restart: cover property (st_q == psfm_pkg::ST_HICCUP ##1 st_q == psfm_pkg::ST_SOFTSTART);
	c_latched: cover property (st_q == psfm_pkg::ST_LATCHED);
	c_pg_up: cover property (!power_good_output ##1 power_good_output);

endmodule // psfm_top
